// [verilog/tcq_regs.sv]
`timescale 1ns/1ps
`include "tcq_cfg.svh"
module tcq_regs
  import tcq_pkg::*;
#(
  parameter int          NTAB       = 8,
  parameter int          PA_BITS    = 52,
  parameter bit          VIRT       = 1'b0,
  parameter logic [23:0] TAB_TYPES  = 24'h000021,
  parameter logic [4:0]  ENTRY_SZ   = 5'h07,
  parameter bit          FIXED_PAGE = 1'b0,
  parameter logic [1:0]  FIXED_PGSZ = 2'h0
)(
  input  wire logic                i_clk,
  input  wire logic                i_rst_n,
  input  wire logic                i_reg_wr,
  input  wire logic                i_reg_rd,
  input  wire logic [15:0]         i_reg_addr,
  input  wire logic [31:0]         i_reg_wdata,
  output logic [31:0]              o_reg_rdata,
  output logic                     o_reg_rvalid,
  input  wire logic                i_xlate_req,
  output logic                     o_xlate_take,
  input  wire logic                i_xlate_busy,
  input  wire logic                i_cache_clean,
  output logic                     o_cmd_req,
  output logic [51:0]              o_cmd_addr,
  output logic [2:0]               o_cmd_inner,
  output logic [2:0]               o_cmd_outer,
  output logic [1:0]               o_cmd_share,
  input  wire logic                i_cmd_ack,
  input  wire logic                i_cmd_err,
  output logic                     o_enabled,
  output logic [NTAB-1:0]          o_tab_valid,
  output logic [2*NTAB-1:0]        o_tab_share,
  output logic [2*NTAB-1:0]        o_tab_pgsz
);

  // ****************************************************************
  // write masks
  // ****************************************************************
  // address bits beyond the implemented width stay zero
  localparam logic [63:0] PA_FIELD = 64'h000f_ffff_ffff_f000;
  localparam logic [63:0] PA_MASK  = PA_FIELD & ((64'h1 << PA_BITS) - 64'h1);
  localparam logic [63:0] CB_MASK  = 64'hb8e0_0000_0000_0cff | PA_MASK;
  localparam logic [31:0] CTRL_VMASK = 32'h0000_00f2;

  // ****************************************************************
  // state
  // ****************************************************************
  logic [63:0] cb_q;
  logic [63:0] cb_d;
  logic [14:0] wr_off_q;
  logic        en_q;
  logic        quiesc_q;
  logic [3:0]  num_q;
  logic        imde_q;
  logic [31:0] rd_mux;
  logic [31:0] tab_rdata;
  logic        tab_hit;
  logic        wr_ctrl;
  logic        wr_cb_lo;
  logic        wr_cb_hi;
  logic        wr_cw_lo;

  tcq_cmd_if cmd ();

  // ****************************************************************
  // address decode
  // ****************************************************************
  // one register word picked by a strobe
  function automatic logic sel(input logic stb, input logic [15:0] a, input logic [15:0] off);
    sel = stb && (a == off);
  endfunction : sel

  assign wr_ctrl  = sel(i_reg_wr, i_reg_addr, `TCQ_OFF_CTRL);
  assign wr_cb_lo = sel(i_reg_wr, i_reg_addr, `TCQ_OFF_CBASE_LO);
  assign wr_cb_hi = sel(i_reg_wr, i_reg_addr, `TCQ_OFF_CBASE_HI);
  assign wr_cw_lo = sel(i_reg_wr, i_reg_addr, `TCQ_OFF_CWR_LO);

  // ****************************************************************
  // control register
  // ****************************************************************
  // enable bit
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      en_q <= `TCQ_RST_EN;
    else if (wr_ctrl)
      en_q <= i_reg_wdata[`TCQ_CTRL_EN];
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      num_q  <= `TCQ_RST_NUM;
      imde_q <= 1'b0;
    end
    else if (wr_ctrl && VIRT)
    begin
      num_q  <= i_reg_wdata[`TCQ_CTRL_NUM_MSB:`TCQ_CTRL_NUM_LSB];
      imde_q <= i_reg_wdata[`TCQ_CTRL_IMDE];
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      quiesc_q <= `TCQ_RST_QUIESC;
    else
      quiesc_q <= !en_q && cmd.idle && !i_xlate_busy && i_cache_clean;
  end

  // ****************************************************************
  // translation gate
  // ****************************************************************
  // requests ignored while off
  assign o_xlate_take = i_xlate_req && en_q;
  assign o_enabled    = en_q;

  // ****************************************************************
  // command queue descriptor
  // ****************************************************************
  // programmable fields
  always_comb
  begin
    cb_d = cb_q;
    if (wr_cb_lo)
      cb_d[31:0] = i_reg_wdata & CB_MASK[31:0];
    else if (wr_cb_hi)
      cb_d[63:32] = i_reg_wdata & CB_MASK[63:32];
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      cb_q <= `TCQ_RST_DESC;
    else
      cb_q <= cb_d;
  end

  // ****************************************************************
  // queue access attributes
  // ****************************************************************
  // decoded from next value, in step with cb_q
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      o_cmd_inner <= 3'h0;
      o_cmd_outer <= 3'h0;
      o_cmd_share <= 2'h0;
    end
    else
    begin
      o_cmd_inner <= cb_d[`TCQ_D_INNER_MSB:`TCQ_D_INNER_LSB];
      o_cmd_outer <= (cb_d[`TCQ_D_OUTER_MSB:`TCQ_D_OUTER_LSB] == 3'h0)
                   ? cb_d[`TCQ_D_INNER_MSB:`TCQ_D_INNER_LSB]
                   : cb_d[`TCQ_D_OUTER_MSB:`TCQ_D_OUTER_LSB];
      o_cmd_share <= tcq_eff_share(cb_d[`TCQ_D_SHARE_MSB:`TCQ_D_SHARE_LSB]);
    end
  end

  // ****************************************************************
  // command write offset
  // ****************************************************************
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      wr_off_q <= `TCQ_RST_OFS;
    else if (wr_cw_lo)
      wr_off_q <= i_reg_wdata[`TCQ_OFS_MSB:`TCQ_OFS_LSB];
  end

  // ****************************************************************
  // engine hookup
  // ****************************************************************
  assign cmd.enable  = en_q;
  assign cmd.q_valid = cb_q[`TCQ_D_VALID];
  assign cmd.base    = {cb_q[`TCQ_D_PA_MSB:`TCQ_D_PA_LSB], 12'h000};
  assign cmd.size    = cb_q[`TCQ_D_SIZE_MSB:`TCQ_D_SIZE_LSB];
  assign cmd.wr_off  = wr_off_q;
  // retry pulse on write of 1
  assign cmd.retry   = wr_cw_lo && i_reg_wdata[`TCQ_OFS_FLAG];
  assign cmd.clear   = wr_cb_lo || wr_cb_hi;

  tcq_cmd_engine u_engine (
    .i_clk      (i_clk),
    .i_rst_n    (i_rst_n),
    .cmd        (cmd),
    .o_cmd_req  (o_cmd_req),
    .o_cmd_addr (o_cmd_addr),
    .i_cmd_ack  (i_cmd_ack),
    .i_cmd_err  (i_cmd_err)
  );

  // ****************************************************************
  // translation table descriptors
  // ****************************************************************
  // table bank
  tcq_table_bank #(
    .NTAB       (NTAB),
    .TAB_TYPES  (TAB_TYPES),
    .ENTRY_SZ   (ENTRY_SZ),
    .FIXED_PAGE (FIXED_PAGE),
    .FIXED_PGSZ (FIXED_PGSZ)
  ) u_tables (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_wr    (i_reg_wr),
    .i_addr  (i_reg_addr),
    .i_wdata (i_reg_wdata),
    .o_hit   (tab_hit),
    .o_rdata (tab_rdata),
    .o_valid (o_tab_valid),
    .o_share (o_tab_share),
    .o_pgsz  (o_tab_pgsz)
  );

  // ****************************************************************
  // read mux
  // ****************************************************************
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (tab_hit)
      rd_mux = tab_rdata;
    else
    begin
      case (i_reg_addr)
        `TCQ_OFF_CTRL:
        begin
          rd_mux[`TCQ_CTRL_EN]     = en_q;
          rd_mux[`TCQ_CTRL_QUIESC] = quiesc_q;
          rd_mux[`TCQ_CTRL_NUM_MSB:`TCQ_CTRL_NUM_LSB] = num_q;
          rd_mux[`TCQ_CTRL_IMDE]   = imde_q;
          if (!VIRT)
            rd_mux = rd_mux & ~CTRL_VMASK;
        end
        `TCQ_OFF_CBASE_LO: rd_mux = cb_q[31:0];
        `TCQ_OFF_CBASE_HI: rd_mux = cb_q[63:32];
        `TCQ_OFF_CWR_LO:
          rd_mux[`TCQ_OFS_MSB:`TCQ_OFS_LSB] = wr_off_q;
        `TCQ_OFF_CRD_LO:
        begin
          rd_mux[`TCQ_OFS_MSB:`TCQ_OFS_LSB] = cmd.rd_off;
          rd_mux[`TCQ_OFS_FLAG]             = cmd.stalled;
        end
        `TCQ_OFF_CWR_HI, `TCQ_OFF_CRD_HI:
          rd_mux = 32'h0000_0000;
        default: rd_mux = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      o_reg_rdata  <= 32'h0000_0000;
      o_reg_rvalid <= 1'b0;
    end
    else
    begin
      o_reg_rvalid <= i_reg_rd;
      if (i_reg_rd)
        o_reg_rdata <= rd_mux;
    end
  end

endmodule : tcq_regs

// [verilog/tcq_cfg.svh]
`ifndef TCQ_CFG_SVH
`define TCQ_CFG_SVH

// ****************************************************************
// register offsets (byte addresses)
// ****************************************************************
`define TCQ_OFF_CTRL        16'h0000
`define TCQ_OFF_CBASE_LO    16'h0080
`define TCQ_OFF_CBASE_HI    16'h0084
`define TCQ_OFF_CWR_LO      16'h0088
`define TCQ_OFF_CWR_HI      16'h008c
`define TCQ_OFF_CRD_LO      16'h0090
`define TCQ_OFF_CRD_HI      16'h0094
`define TCQ_OFF_TAB_BASE    16'h0100

// ****************************************************************
// control register fields
// ****************************************************************
`define TCQ_CTRL_EN         0
`define TCQ_CTRL_IMDE       1
`define TCQ_CTRL_NUM_LSB    4
`define TCQ_CTRL_NUM_MSB    7
`define TCQ_CTRL_QUIESC     31

// ****************************************************************
// descriptor fields (64-bit positions)
// ****************************************************************
`define TCQ_D_VALID         63
`define TCQ_D_INNER_MSB     61
`define TCQ_D_INNER_LSB     59
`define TCQ_D_TYPE_MSB      58
`define TCQ_D_TYPE_LSB      56
`define TCQ_D_OUTER_MSB     55
`define TCQ_D_OUTER_LSB     53
`define TCQ_D_ESZ_MSB       52
`define TCQ_D_ESZ_LSB       48
`define TCQ_D_TPA_MSB       47
`define TCQ_D_PA_MSB        51
`define TCQ_D_PA_LSB        12
`define TCQ_D_SHARE_MSB     11
`define TCQ_D_SHARE_LSB     10
`define TCQ_D_PGSZ_MSB      9
`define TCQ_D_PGSZ_LSB      8
`define TCQ_D_SIZE_MSB      7
`define TCQ_D_SIZE_LSB      0

// ****************************************************************
// offset registers
// ****************************************************************
`define TCQ_OFS_MSB         19
`define TCQ_OFS_LSB         5
`define TCQ_OFS_FLAG        0
`define TCQ_SLOT_SHIFT      5
`define TCQ_PAGE_SLOT_SHIFT 7

// ****************************************************************
// reset values
// ****************************************************************
`define TCQ_RST_EN          1'b0
`define TCQ_RST_QUIESC      1'b1
`define TCQ_RST_DESC        64'h0000_0000_0000_0000
`define TCQ_RST_OFS         15'h0000
`define TCQ_RST_NUM         4'h0

`endif

// [verilog/tcq_pkg.sv]
package tcq_pkg;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {
    TCQ_IDLE  = 2'b00,
    TCQ_FETCH = 2'b01,
    TCQ_STALL = 2'b10
  } tcq_state_type;

  typedef enum logic [1:0] {
    TCQ_SH_NONE  = 2'b00,
    TCQ_SH_INNER = 2'b01,
    TCQ_SH_OUTER = 2'b10
  } tcq_share_type;

  typedef enum logic [1:0] {
    TCQ_PG_4K  = 2'b00,
    TCQ_PG_16K = 2'b01,
    TCQ_PG_64K = 2'b10
  } tcq_pgsz_type;

  // reserved share code acts as non-shareable
  function automatic tcq_share_type tcq_eff_share(input logic [1:0] raw);
    tcq_eff_share = (raw == 2'h3) ? TCQ_SH_NONE : tcq_share_type'(raw);
  endfunction : tcq_eff_share

  // reserved page code acts as the largest page
  function automatic tcq_pgsz_type tcq_eff_pgsz(input logic [1:0] raw);
    tcq_eff_pgsz = (raw == 2'h3) ? TCQ_PG_64K : tcq_pgsz_type'(raw);
  endfunction : tcq_eff_pgsz

endpackage : tcq_pkg

// [verilog/tcq_cmd_if.sv]
`timescale 1ns/1ps
interface tcq_cmd_if;
  logic        enable;
  logic        q_valid;
  logic [51:0] base;
  logic [7:0]  size;
  logic [14:0] wr_off;
  logic        retry;
  logic        clear;
  logic [14:0] rd_off;
  logic        stalled;
  logic        idle;

  modport ctl (output enable, q_valid, base, size, wr_off, retry, clear,
               input  rd_off, stalled, idle);
  modport eng (input  enable, q_valid, base, size, wr_off, retry, clear,
               output rd_off, stalled, idle);
endinterface : tcq_cmd_if

// [verilog/tcq_table_bank.sv]
`timescale 1ns/1ps
`include "tcq_cfg.svh"
module tcq_table_bank
  import tcq_pkg::*;
#(
  parameter int          NTAB       = 8,
  parameter logic [23:0] TAB_TYPES  = 24'h000021,
  parameter logic [4:0]  ENTRY_SZ   = 5'h07,
  parameter bit          FIXED_PAGE = 1'b0,
  parameter logic [1:0]  FIXED_PGSZ = 2'h0
)(
  input  wire logic                i_clk,
  input  wire logic                i_rst_n,
  input  wire logic                i_wr,
  input  wire logic [15:0]         i_addr,
  input  wire logic [31:0]         i_wdata,
  output logic                     o_hit,
  output logic [31:0]              o_rdata,
  output logic [NTAB-1:0]          o_valid,
  output logic [2*NTAB-1:0]        o_share,
  output logic [2*NTAB-1:0]        o_pgsz
);

  // ****************************************************************
  // storage and masks
  // ****************************************************************
  localparam logic [63:0] WMASK = 64'hbbe0_ffff_ffff_ffff;
  logic [63:0] tab_q [NTAB];
  logic [63:0] tab_view [NTAB];
  logic [2:0]  idx;
  logic        hit;

  assign idx   = i_addr[5:3];
  assign hit   = (i_addr[15:6] == `TCQ_OFF_TAB_BASE >> 6) && (int'(idx) < NTAB);
  assign o_hit = (i_addr[15:6] == `TCQ_OFF_TAB_BASE >> 6);

  function automatic logic [63:0] view(input int n, input logic [63:0] raw);
    logic [63:0] v;
    v = raw;
    v[`TCQ_D_TYPE_MSB:`TCQ_D_TYPE_LSB] = TAB_TYPES[3*n +: 3];
    v[`TCQ_D_ESZ_MSB:`TCQ_D_ESZ_LSB]   = ENTRY_SZ;
    if (FIXED_PAGE)
      v[`TCQ_D_PGSZ_MSB:`TCQ_D_PGSZ_LSB] = FIXED_PGSZ;
    if (TAB_TYPES[3*n +: 3] == 3'h0)
      v[`TCQ_D_SIZE_MSB:`TCQ_D_SIZE_LSB] = 8'h00;
    view = v;
  endfunction : view

  // visible value of each descriptor
  always_comb
  begin
    for (int n = 0; n < NTAB; n++)
      tab_view[n] = view(n, tab_q[n]);
  end

  // ****************************************************************
  // write path
  // ****************************************************************
  always_ff @(posedge i_clk)
  begin
    for (int n = 0; n < NTAB; n++)
    begin
      if (!i_rst_n)
        tab_q[n] <= `TCQ_RST_DESC;
      else if (i_wr && hit && int'(idx) == n)
      begin
        if (i_addr[2])
          tab_q[n][63:32] <= i_wdata & WMASK[63:32];
        else
          tab_q[n][31:0] <= i_wdata & WMASK[31:0];
      end
    end
  end

  // ****************************************************************
  // read and decoded outputs
  // ****************************************************************
  always_comb
  begin
    o_rdata = 32'h0000_0000;
    for (int n = 0; n < NTAB; n++)
      if (hit && int'(idx) == n)
        o_rdata = i_addr[2] ? tab_view[n][63:32] : tab_view[n][31:0];
  end

  always_comb
  begin
    for (int n = 0; n < NTAB; n++)
    begin
      o_valid[n] = tab_q[n][`TCQ_D_VALID];
      o_share[2*n +: 2] = tcq_eff_share(tab_q[n][`TCQ_D_SHARE_MSB:`TCQ_D_SHARE_LSB]);
      o_pgsz[2*n +: 2]  = tcq_eff_pgsz(tab_view[n][`TCQ_D_PGSZ_MSB:`TCQ_D_PGSZ_LSB]);
    end
  end

endmodule : tcq_table_bank

// [verilog/tcq_cmd_engine.sv]
`timescale 1ns/1ps
`include "tcq_cfg.svh"
module tcq_cmd_engine
  import tcq_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  tcq_cmd_if.eng           cmd,
  output logic             o_cmd_req,
  output logic [51:0]      o_cmd_addr,
  input  wire logic        i_cmd_ack,
  input  wire logic        i_cmd_err
);

  tcq_state_type state_q;
  logic [14:0]   off_q;
  logic [15:0]   limit;
  logic [15:0]   nxt;
  logic [14:0]   off_d;
  logic          issue;

  // ****************************************************************
  // wrap arithmetic
  // ****************************************************************
  // queue is circular
  assign limit = 16'(({8'h00, cmd.size} + 16'h0001) << `TCQ_PAGE_SLOT_SHIFT);
  assign nxt   = {1'b0, off_q} + 16'h0001;
  assign off_d = (nxt >= limit) ? 15'h0000 : nxt[14:0];

  assign issue = cmd.enable && cmd.q_valid && (off_q != cmd.wr_off);

  // ****************************************************************
  // sequencer
  // ****************************************************************
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      state_q <= TCQ_IDLE;
      off_q   <= `TCQ_RST_OFS;
    end
    else if (cmd.clear)
    begin
      state_q <= TCQ_IDLE;
      off_q   <= `TCQ_RST_OFS;
    end
    else
    begin
      unique case (state_q)
        TCQ_IDLE:
          if (issue)
            state_q <= TCQ_FETCH;
        TCQ_FETCH:
          if (i_cmd_ack)
          begin
            if (i_cmd_err)
              state_q <= TCQ_STALL;
            else
            begin
              state_q <= TCQ_IDLE;
              off_q   <= off_d;
            end
          end
        TCQ_STALL:
          if (cmd.retry)
            state_q <= TCQ_IDLE;
        default:
          state_q <= TCQ_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      o_cmd_addr <= 52'h0;
    else if (state_q == TCQ_IDLE && issue)
      o_cmd_addr <= {cmd.base[51:16], 16'h0000} + {32'h0, off_q, 5'h00};
  end

  assign o_cmd_req   = (state_q == TCQ_FETCH);
  assign cmd.rd_off  = off_q;
  assign cmd.stalled = (state_q == TCQ_STALL);
  assign cmd.idle    = (state_q != TCQ_FETCH);

endmodule : tcq_cmd_engine

// [tb/tcq_regs_sva.sv]
`timescale 1ns/1ps
// ****
// port checker
// ****
module tcq_regs_chk #(
  parameter int NTAB = 8
)(
  input wire logic               i_clk,
  input wire logic               i_rst_n,
  input wire logic               i_reg_wr,
  input wire logic               i_reg_rd,
  input wire logic [15:0]        i_reg_addr,
  input wire logic [31:0]        i_reg_wdata,
  input wire logic               o_reg_rvalid,
  input wire logic               i_xlate_req,
  input wire logic               o_xlate_take,
  input wire logic               o_cmd_req,
  input wire logic [51:0]        o_cmd_addr,
  input wire logic [1:0]         o_cmd_share,
  input wire logic               i_cmd_ack,
  input wire logic               i_cmd_err,
  input wire logic               o_enabled,
  input wire logic [2*NTAB-1:0]  o_tab_share,
  input wire logic [2*NTAB-1:0]  o_tab_pgsz
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  rd_answer_a: assert property (i_reg_rd |=> o_reg_rvalid)
    else $error("read got no answer");
  answer_cause_a: assert property (o_reg_rvalid |-> $past(i_reg_rd))
    else $error("answer without a read");
  req_hold_a: assert property (o_cmd_req && !i_cmd_ack && !i_reg_wr |=>
    o_cmd_req && $stable(o_cmd_addr)) else $error("fetch request not held");
  req_drop_a: assert property (o_cmd_req && i_cmd_ack |=> !o_cmd_req)
    else $error("fetch request not dropped");
  req_enabled_a: assert property ($rose(o_cmd_req) |-> $past(o_enabled))
    else $error("fetch while disabled");
  take_gate_a: assert property (o_xlate_take == (i_xlate_req && o_enabled))
    else $error("translation gate wrong");
  enable_wr_a: assert property (i_reg_wr && i_reg_addr == 16'h0000 |=>
    o_enabled == $past(i_reg_wdata[0])) else $error("enable bit not written");
  slot_align_a: assert property (o_cmd_req |-> o_cmd_addr[4:0] == 5'h00)
    else $error("fetch address not slot aligned");
  queue_share_a: assert property (o_cmd_share != 2'h3)
    else $error("queue share reserved code");
  table_codes_a: assert property (o_tab_share[1:0] != 2'h3 && o_tab_pgsz[1:0] != 2'h3)
    else $error("table reserved code");
  abort_fetch_a: assert property (i_reg_wr && i_reg_addr[15:3] == 13'h0010 |=>
    !o_cmd_req) else $error("descriptor write kept fetch");

  cover property (o_reg_rvalid);
  cover property (o_cmd_req && i_cmd_ack && !i_cmd_err);
  cover property (o_cmd_req && i_cmd_ack && i_cmd_err);
endmodule : tcq_regs_chk

bind tcq_regs tcq_regs_chk #(.NTAB(NTAB)) tcq_regs_chk_i (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
  .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rvalid(o_reg_rvalid),
  .i_xlate_req(i_xlate_req), .o_xlate_take(o_xlate_take), .o_cmd_req(o_cmd_req),
  .o_cmd_addr(o_cmd_addr), .o_cmd_share(o_cmd_share), .i_cmd_ack(i_cmd_ack),
  .i_cmd_err(i_cmd_err), .o_enabled(o_enabled), .o_tab_share(o_tab_share),
  .o_tab_pgsz(o_tab_pgsz));

// [tb/tcq_regs_test.sv]
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module tcq_regs_test
  import tcq_pkg::*;
;
  localparam logic [51:0] BASE = 52'h0_0000_1234_0000;
  logic        i_clk = 1'b0, i_rst_n = 1'b0, i_reg_wr = 1'b0, i_reg_rd = 1'b0;
  logic [15:0] i_reg_addr = 16'h0000;
  logic [31:0] i_reg_wdata = 32'h0000_0000, o_reg_rdata;
  logic        i_xlate_req = 1'b0, i_xlate_busy = 1'b0, i_cache_clean = 1'b1;
  logic        i_cmd_ack = 1'b0, i_cmd_err = 1'b0;
  logic        o_reg_rvalid, o_xlate_take, o_cmd_req, o_enabled;
  logic [51:0] o_cmd_addr;
  logic [2:0]  o_cmd_inner, o_cmd_outer;
  logic [1:0]  o_cmd_share;
  logic [15:0] o_tab_share, o_tab_pgsz;
  logic [7:0]  o_tab_valid;
  int          n_fail = 0, n_tests = 0;

  tcq_regs tcq_regs_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid), .i_xlate_req(i_xlate_req),
    .o_xlate_take(o_xlate_take), .i_xlate_busy(i_xlate_busy),
    .i_cache_clean(i_cache_clean), .o_cmd_req(o_cmd_req), .o_cmd_addr(o_cmd_addr),
    .o_cmd_inner(o_cmd_inner), .o_cmd_outer(o_cmd_outer), .o_cmd_share(o_cmd_share),
    .i_cmd_ack(i_cmd_ack), .i_cmd_err(i_cmd_err), .o_enabled(o_enabled),
    .o_tab_valid(o_tab_valid), .o_tab_share(o_tab_share), .o_tab_pgsz(o_tab_pgsz));

  always #50 i_clk = ~i_clk;

  // ****
  // bus and fetch helpers
  // ****
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(negedge i_clk);
    i_reg_wr = 1'b1;
    i_reg_addr = a;
    i_reg_wdata = d;
    @(negedge i_clk);
    i_reg_wr = 1'b0;
  endtask : wr

  task automatic rd_chk(input logic [15:0] a, input logic [31:0] m, input logic [31:0] e);
    @(negedge i_clk);
    i_reg_rd = 1'b1;
    i_reg_addr = a;
    @(negedge i_clk);
    i_reg_rd = 1'b0;
    `CHK(o_reg_rvalid, 1'b1)
    `CHK(o_reg_rdata & m, e)
  endtask : rd_chk

  task automatic serve(input int s, input int n, input logic e);
    int k;
    for (int i = 0; i < n; i++)
    begin
      k = 0;
      while (o_cmd_req !== 1'b1 && k < 20)
      begin
        @(negedge i_clk);
        k++;
      end
      `CHK(o_cmd_req, 1'b1)
      `CHK(o_cmd_addr, BASE + 52'(((s + i) % 128) * 32))
      i_cmd_ack = 1'b1;
      i_cmd_err = e;
      @(negedge i_clk);
      i_cmd_ack = 1'b0;
      i_cmd_err = 1'b0;
      @(negedge i_clk);
    end
  endtask : serve

  task automatic idle_chk();
    repeat (6) @(negedge i_clk);
    `CHK(o_cmd_req, 1'b0)
  endtask : idle_chk

  // ****
  // scenarios
  // ****
  task automatic t_reset();
    rd_chk(16'h0000, 32'hffff_ffff, 32'h8000_0000);
    rd_chk(16'h0084, 32'hffff_ffff, 32'h0000_0000);
    rd_chk(16'h0090, 32'hffff_ffff, 32'h0000_0000);
  endtask : t_reset

  task automatic t_table();
    for (int c = 0; c < 4; c++)
    begin
      wr(16'h0100, {20'h0, c[1:0], c[1:0], 8'h5a});
      rd_chk(16'h0100, 32'h0000_00ff, 32'h0000_005a);
      `CHK(o_tab_share[1:0], (c == 3) ? 2'h0 : c[1:0])
      `CHK(o_tab_pgsz[1:0], (c == 3) ? 2'h2 : c[1:0])
    end
    wr(16'h0104, 32'h8000_0000);
    `CHK(o_tab_valid, 8'h01)
    rd_chk(16'h0100, 32'h0000_00ff, 32'h0000_005a);
    wr(16'h0110, 32'h0000_00ff);
    rd_chk(16'h0110, 32'h0000_00ff, 32'h0000_0000);
  endtask : t_table

  // descriptor set up while disabled and quiescent
  task automatic t_queue();
    wr(16'h0084, 32'hef10_0000);
    rd_chk(16'h0084, 32'hffff_ffff, 32'ha800_0000);
    `CHK(o_cmd_inner, 3'h5)
    `CHK(o_cmd_outer, 3'h5)
    wr(16'h0084, 32'ha840_0000);
    `CHK(o_cmd_outer, 3'h2)
    wr(16'h0080, 32'h1234_5f00);
    rd_chk(16'h0080, 32'hffff_f3ff, 32'h1234_5000);
    rd_chk(16'h0084, 32'hffff_ffff, 32'ha840_0000);
    `CHK(o_cmd_share, TCQ_SH_NONE)
  endtask : t_queue

  // base bits 15:12 set above must not reach the fetch address
  task automatic t_fetch();
    wr(16'h0000, 32'h0000_00f3);
    rd_chk(16'h0000, 32'h7fff_ffff, 32'h0000_0001);
    `CHK(o_enabled, 1'b1)
    i_xlate_req = 1'b1;
    @(negedge i_clk);
    `CHK(o_xlate_take, 1'b1)
    wr(16'h0088, 32'h0000_0fe0);
    serve(0, 127, 1'b0);
    rd_chk(16'h0090, 32'hffff_ffff, 32'h0000_0fe0);
    wr(16'h0088, 32'h0000_0000);
    serve(127, 1, 1'b0);
    rd_chk(16'h0090, 32'hffff_ffff, 32'h0000_0000);
  endtask : t_fetch

  task automatic t_stall();
    wr(16'h0088, 32'h0000_0020);
    serve(0, 1, 1'b1);
    rd_chk(16'h0090, 32'hffff_ffff, 32'h0000_0001);
    idle_chk();
    wr(16'h0088, 32'h0000_0021);
    serve(0, 1, 1'b0);
    rd_chk(16'h0090, 32'hffff_ffff, 32'h0000_0020);
  endtask : t_stall

  task automatic t_disable();
    wr(16'h0000, 32'h0000_0000);
    @(negedge i_clk);
    `CHK(o_xlate_take, 1'b0)
    `CHK(o_enabled, 1'b0)
    wr(16'h0088, 32'h0000_0040);
    idle_chk();
    rd_chk(16'h0090, 32'hffff_ffff, 32'h0000_0020);
    rd_chk(16'h0000, 32'hffff_ffff, 32'h8000_0000);
    i_xlate_busy = 1'b1;
    repeat (2) @(negedge i_clk);
    rd_chk(16'h0000, 32'hffff_ffff, 32'h0000_0000);
    i_xlate_busy = 1'b0;
    repeat (2) @(negedge i_clk);
    wr(16'h0080, 32'h1234_0000);
    rd_chk(16'h0090, 32'hffff_ffff, 32'h0000_0000);
    rd_chk(16'h0094, 32'hffff_ffff, 32'h0000_0000);
  endtask : t_disable

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : complete_run

  initial
  begin
    repeat (20) @(negedge i_clk);
    i_rst_n = 1'b1;
    t_reset();
    t_table();
    t_queue();
    t_fetch();
    t_stall();
    t_disable();
    complete_run();
  end

  initial
  begin
    #500000;
    n_fail++;
    complete_run();
  end
endmodule : tcq_regs_test
